// ---- dsp_alu_map.svh ----
// Register offsets, field positions and reset values of the compute datapath
`ifndef DSP_ALU_MAP_SVH
`define DSP_ALU_MAP_SVH

// Byte offsets on the register bus
`define OFS_CMD 8'h00
`define OFS_MODE 8'h04
`define OFS_ARITH_STATUS_WORD 8'h08
`define OFS_STICKY_STATUS_WORD 8'h0C
`define OFS_STICKY_STATUS_WORD_CLR 8'h10
`define OFS_STICKY_STATUS_WORD_EN 8'h14
`define OFS_ACC_BASE 8'h20
`define OFS_ACC_LAST 8'h34
`define OFS_RF_BASE 8'h40
`define OFS_RF_LAST 8'h7C

// Command word fields
`define CMD_OP_LSB 0
`define CMD_RN_LSB 8
`define CMD_RM_LSB 12
`define CMD_RX_LSB 16
`define CMD_RY_LSB 20
`define CMD_FMT_LSB 24
`define CMD_BG_BIT 28
`define CMD_FMTGIVEN_BIT 29
`define CMD_TOREG_BIT 30

// Format nibble: x signed, y signed, fractional, rounded
`define FMT_XS 3
`define FMT_YS 2
`define FMT_FRAC 1
`define FMT_RND 0
`define FMT_SF 4'hE
`define FMT_SI 4'hC

// Mode control bits
`define MODE_SAT 0
`define MODE_TRUNC 1
`define MODE_RND32 2
`define MODE_RESET 32'h00000000

// Arithmetic status bits
`define AST_AZ 0
`define AST_AV 1
`define AST_AN 2
`define AST_AC 3
`define AST_MN 4
`define AST_MV 5
`define AST_AI 6
`define AST_TF 8
`define AST_FLAG_LSB 16
`define AST_CACC_LSB 24

// Sticky status bits; stack bits are live, not sticky
`define STK_AOS 0
`define STK_MOS 1
`define STK_FOS 2
`define STK_FUS 3
`define STK_FIS 4
`define STK_CB_LSB 5
`define STK_STACK_LSB 8
`define STK_STICKY_MASK 32'h0000007F

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define FLOAT_QNAN 32'h7FC00000

`endif

// ---- dsp_alu_pkg.sv ----
// Types shared by the compute datapath
package dsp_alu_pkg;

	typedef enum logic [5:0] {
		OP_ADD = 6'h00, OP_SUB = 6'h01, OP_ADDSUB = 6'h02, OP_ADDCI = 6'h03,
		OP_SUBCI = 6'h04, OP_AVG = 6'h05, OP_COMP = 6'h06, OP_NEG = 6'h07,
		OP_ABS = 6'h08, OP_PASS = 6'h09, OP_MIN = 6'h0A, OP_MAX = 6'h0B,
		OP_CLIP = 6'h0C, OP_INCCI = 6'h0D, OP_DECCI = 6'h0E, OP_INC = 6'h0F,
		OP_DEC = 6'h10, OP_AND = 6'h11, OP_OR = 6'h12, OP_XOR = 6'h13,
		OP_NOT = 6'h14, OP_FADD = 6'h18, OP_FSUB = 6'h19, OP_FADDSUB = 6'h1A,
		OP_MUL = 6'h20, OP_MACP = 6'h21, OP_MACM = 6'h22, OP_ACLR = 6'h23,
		OP_ASAT = 6'h24, OP_ARND = 6'h25, OP_ATOREG = 6'h26, OP_REGTOACC = 6'h27
	} alu_op_t;

	typedef logic [79:0] acc_t;

endpackage : dsp_alu_pkg

// ---- dsp_alu_multiplier_core.sv ----
// Fixed/floating ALU and multiplier-accumulator datapath behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "dsp_alu_map.svh"

module dsp_alu_multiplier_core
	import dsp_alu_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic [3:0] FLAG_IN,
	input wire logic [1:0] CBUF_OVF,
	input wire logic [2:0] STACK_STAT,
	output logic IRQ
);

	logic [31:0] rf_q [16];
	acc_t fg_q, bg_q;
	logic [31:0] mode_q, arith_status_word_q, sticky_q, sticky_status_word_en_q, cmd_q;
	logic go_q;
	logic aw_have_q, w_have_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [3:0] flag_s1_q, flag_s2_q, flag_s3_q, flag_q;

	// Fixed add returning {carry, overflow, sum}
	function automatic logic [33:0] fx_add(input logic [31:0] a, input logic [31:0] b, input logic c);
		logic [32:0] s;
		s = {1'b0, a} + {1'b0, b} + {32'h0, c};
		return {s[32], (a[31] == b[31]) && (s[31] != a[31]), s[31:0]};
	endfunction : fx_add

	// Single-precision add returning {overflow, underflow, invalid, result}; denormals flush to zero
	function automatic logic [34:0] fl_add(input logic [31:0] a, input logic [31:0] b, input logic trunc);
		logic [31:0] h, l;
		logic [26:0] mh, ml;
		logic [27:0] s;
		logic signed [9:0] e;
		logic [7:0] d;
		logic [24:0] mr;
		logic iv, ov, un;
		h = (a[30:0] < b[30:0]) ? b : a;
		l = (a[30:0] < b[30:0]) ? a : b;
		iv = (a[30:23] == 8'hFF) || (b[30:23] == 8'hFF);
		mh = {|h[30:23], h[22:0], 3'h0};
		ml = {|l[30:23], l[22:0], 3'h0};
		d = h[30:23] - l[30:23];
		ml = (d > 8'd26) ? 27'h0 : (ml >> d);
		s = (h[31] == l[31]) ? {1'b0, mh} + {1'b0, ml} : {1'b0, mh} - {1'b0, ml};
		e = {2'b00, h[30:23]};
		if (s[27]) begin
			s = s >> 1;
			e = e + 10'sd1;
		end
		for (int i = 0; i < 26; i++) begin
			if (!s[26] && s != 28'h0) begin
				s = s << 1;
				e = e - 10'sd1;
			end
		end
		// Round to nearest unless truncation is selected
		mr = {1'b0, s[26:3]} + {24'h0, !trunc && s[2]};
		if (mr[24]) begin
			mr = mr >> 1;
			e = e + 10'sd1;
		end
		ov = !iv && (e >= 10'sd255) && s != 28'h0;
		un = !iv && (e <= 10'sd0) && s != 28'h0;
		if (iv) return {3'b001, `FLOAT_QNAN};
		if (s == 28'h0 || h[30:23] == 8'h00) return {3'b000, 32'h0};
		if (ov) return {3'b100, h[31], 8'hFF, 23'h0};
		if (un) return {3'b010, h[31], 31'h0};
		return {3'b000, h[31], e[7:0], mr[22:0]};
	endfunction : fl_add

	// Accumulator value fits a 32-bit register under the given format
	function automatic logic acc_fits(input acc_t v, input logic [3:0] f);
		if (f[`FMT_FRAC]) return (v[79:63] == {17{v[79]}});
		if (f[`FMT_XS]) return (v[79:31] == {49{v[79]}});
		return (v[79:32] == 48'h0);
	endfunction : acc_fits

	// Accumulator clamped to the nearest limit of the format
	function automatic acc_t acc_sat(input acc_t v, input logic [3:0] f);
		if (acc_fits(v, f)) return v;
		if (f[`FMT_FRAC]) return v[79] ? {16'hFFFF, 32'h80000000, 32'h0} : {16'h0, 32'h7FFFFFFF, 32'hFFFFFFFF};
		if (f[`FMT_XS]) return v[79] ? {48'hFFFFFFFFFFFF, 32'h80000000} : {48'h0, 32'h7FFFFFFF};
		return {48'h0, 32'hFFFFFFFF};
	endfunction : acc_sat

	// Decoded command
	alu_op_t op;
	logic [3:0] rn, rm, rx, ry, fmt;
	logic [31:0] x, y, ci32;
	logic use_bg, to_reg, one_in;
	assign op = alu_op_t'(cmd_q[`CMD_OP_LSB +: 6]);
	assign rn = cmd_q[`CMD_RN_LSB +: 4];
	assign rm = cmd_q[`CMD_RM_LSB +: 4];
	assign rx = cmd_q[`CMD_RX_LSB +: 4];
	assign ry = cmd_q[`CMD_RY_LSB +: 4];
	assign x = rf_q[rx];
	assign y = rf_q[ry];
	assign use_bg = cmd_q[`CMD_BG_BIT];
	assign to_reg = cmd_q[`CMD_TOREG_BIT];
	assign one_in = (op == OP_ASAT) || (op == OP_ARND) || (op == OP_ATOREG);
	// Missing format: one-input ops are signed fractional, products signed integer
	assign fmt = cmd_q[`CMD_FMTGIVEN_BIT] ? cmd_q[`CMD_FMT_LSB +: 4] : (one_in ? `FMT_SF : `FMT_SI);
	assign ci32 = {31'h0, arith_status_word_q[`AST_AC]};

	// Result of the operation held in the command register
	logic [31:0] res_a, res_b;
	logic wr_a, wr_b, fix_op, mul_op, acc_wr, flt_op;
	logic [33:0] fr, fs;
	logic [34:0] fa, fb;
	logic [32:0] avg;
	logic [31:0] lim;
	acc_t acc_src, acc_new, prod, sat_v;
	logic [65:0] p66;
	logic mv, ai, fov, fun;
	always_comb begin
		res_a = 32'h0;
		res_b = 32'h0;
		wr_a = 1'b0;
		wr_b = 1'b0;
		fix_op = 1'b1;
		flt_op = 1'b0;
		mul_op = 1'b0;
		acc_wr = 1'b0;
		fr = 34'h0;
		fs = fx_add(x, ~y, 1'b1);
		sat_v = '0;
		mv = 1'b0;
		avg = {x[31], x} + {y[31], y};
		lim = y[31] ? -y : y;
		acc_src = use_bg ? bg_q : fg_q;
		p66 = 66'($signed({fmt[`FMT_XS] & x[31], x}) * $signed({fmt[`FMT_YS] & y[31], y}));
		prod = {{14{p66[65]}}, p66};
		if (fmt[`FMT_FRAC]) prod = prod << 1;
		acc_new = acc_src;
		fa = fl_add(x, y, mode_q[`MODE_TRUNC]);
		fb = fl_add(x, {~y[31], y[30:0]}, mode_q[`MODE_TRUNC]);
		case (op)
			OP_ADD, OP_ADDSUB: fr = fx_add(x, y, 1'b0);
			OP_SUB, OP_COMP: fr = fx_add(x, ~y, 1'b1);
			OP_ADDCI: fr = fx_add(x, y, ci32[0]);
			OP_SUBCI: fr = fx_add(x, ~y, ci32[0]);
			OP_AVG: fr = {2'b00, avg[32:1]};
			OP_NEG: fr = fx_add(32'h0, ~x, 1'b1);
			OP_ABS: fr = x[31] ? fx_add(32'h0, ~x, 1'b1) : {2'b00, x};
			OP_PASS: fr = {2'b00, x};
			OP_MIN: fr = {2'b00, ($signed(x) < $signed(y)) ? x : y};
			OP_MAX: fr = {2'b00, ($signed(x) > $signed(y)) ? x : y};
			OP_CLIP: fr = {2'b00, ($signed(x) > $signed(lim)) ? lim : (($signed(x) < $signed(-lim)) ? -lim : x)};
			OP_INCCI: fr = fx_add(x, 32'h0, ci32[0]);
			OP_DECCI: fr = fx_add(x, 32'hFFFFFFFF, ci32[0]);
			OP_INC: fr = fx_add(x, 32'h0, 1'b1);
			OP_DEC: fr = fx_add(x, 32'hFFFFFFFF, 1'b0);
			OP_AND: fr = {2'b00, x & y};
			OP_OR: fr = {2'b00, x | y};
			OP_XOR: fr = {2'b00, x ^ y};
			OP_NOT: fr = {2'b00, ~x};
			OP_FADD, OP_FSUB, OP_FADDSUB: begin
				fix_op = 1'b0;
				flt_op = 1'b1;
			end
			default: begin
				fix_op = 1'b0;
				mul_op = 1'b1;
			end
		endcase
		// Saturation replaces an overflowed fixed result with the nearest limit
		res_a = (mode_q[`MODE_SAT] && fr[32]) ? (fr[31] ? 32'h7FFFFFFF : 32'h80000000) : fr[31:0];
		wr_a = fix_op && op != OP_COMP;
		if (op == OP_ADDSUB) begin
			res_b = fs[31:0];
			if (mode_q[`MODE_SAT] && res_b[31] != x[31] && x[31] != y[31]) res_b = x[31] ? 32'h80000000 : 32'h7FFFFFFF;
			wr_b = 1'b1;
		end
		if (flt_op) begin
			res_a = (op == OP_FSUB) ? fb[31:0] : fa[31:0];
			res_b = fb[31:0];
			wr_a = 1'b1;
			wr_b = (op == OP_FADDSUB);
		end
		if (mul_op) begin
			case (op)
				OP_MUL: acc_new = prod;
				OP_MACP: acc_new = acc_src + prod;
				OP_MACM: acc_new = acc_src - prod;
				OP_ACLR: acc_new = '0;
				OP_ASAT: acc_new = acc_sat(acc_src, fmt);
				default: acc_new = acc_src;
			endcase
			// Rounding keeps the upper word and clears the low word
			if ((op == OP_ARND) || (fmt[`FMT_RND] && fmt[`FMT_FRAC] && op != OP_ACLR && op != OP_ASAT))
				acc_new = (acc_new + 80'h80000000) & {48'hFFFFFFFFFFFF, 32'h0};
			mv = !acc_fits(acc_new, fmt);
			acc_wr = !to_reg && op != OP_ATOREG && op != OP_REGTOACC;
			wr_a = to_reg || op == OP_ATOREG;
			sat_v = acc_sat(acc_new, fmt);
			res_a = fmt[`FMT_FRAC] ? sat_v[63:32] : sat_v[31:0];
			if (op == OP_ATOREG) begin
				case (fmt[1:0])
					2'h2: res_a = {{16{acc_src[79]}}, acc_src[79:64]};
					2'h1: res_a = acc_src[63:32];
					default: res_a = acc_src[31:0];
				endcase
			end
		end
		ai = flt_op && fa[32];
		fov = flt_op && (op == OP_FADD ? fa[34] : (fb[34] | (op == OP_FADDSUB && fa[34])));
		fun = flt_op && (op == OP_FADD ? fa[33] : (fb[33] | (op == OP_FADDSUB && fa[33])));
	end

	// AXI4-Lite write side: address and data taken in either order, answer after both
	logic wr_go;
	logic [31:0] bmask;
	logic w_ok;
	assign wr_go = aw_have_q && w_have_q && !BVALID;
	assign bmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign w_ok = aw_addr_q[1:0] == 2'h0 && (aw_addr_q <= `OFS_STICKY_STATUS_WORD_EN || (aw_addr_q >= `OFS_ACC_BASE
		&& aw_addr_q <= `OFS_ACC_LAST) || aw_addr_q >= `OFS_RF_BASE);
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			AWREADY <= 1'b1;
			WREADY <= 1'b1;
			BVALID <= 1'b0;
			BRESP <= `RESP_OKAY;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= AWADDR;
				AWREADY <= 1'b0;
			end
			if (WVALID && WREADY) begin
				w_have_q <= 1'b1;
				w_data_q <= WDATA;
				w_strb_q <= WSTRB;
				WREADY <= 1'b0;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				BVALID <= 1'b1;
				BRESP <= w_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (BVALID && BREADY) begin
				BVALID <= 1'b0;
				AWREADY <= 1'b1;
				WREADY <= 1'b1;
			end
		end
	end

	logic bus_wr;
	logic [31:0] wval;
	assign bus_wr = wr_go && w_ok;

	// Control words and the one-cycle launch of a compute command
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			mode_q <= `MODE_RESET;
			sticky_status_word_en_q <= 32'h0;
			cmd_q <= 32'h0;
			go_q <= 1'b0;
		end else begin
			go_q <= bus_wr && aw_addr_q == `OFS_CMD;
			if (bus_wr && aw_addr_q == `OFS_CMD) cmd_q <= (cmd_q & ~bmask) | (w_data_q & bmask);
			if (bus_wr && aw_addr_q == `OFS_MODE) mode_q <= (mode_q & ~bmask) | (w_data_q & bmask);
			if (bus_wr && aw_addr_q == `OFS_STICKY_STATUS_WORD_EN) sticky_status_word_en_q <= (sticky_status_word_en_q & ~bmask) | (w_data_q & bmask);
		end
	end

	// Register file; a bus write never meets a commit since a command needs its own write
	generate
		for (genvar i = 0; i < 16; i++) begin : g_rf
			always_ff @(posedge CLOCK or posedge RST) begin
				if (RST) begin
					rf_q[i] <= 32'h0;
				end else if (bus_wr && aw_addr_q == `OFS_RF_BASE + 8'(4 * i)) begin
					rf_q[i] <= (rf_q[i] & ~bmask) | (w_data_q & bmask);
				end else if (go_q && wr_a && rn == 4'(i)) begin
					rf_q[i] <= res_a;
				end else if (go_q && wr_b && rm == 4'(i)) begin
					rf_q[i] <= res_b;
				end
			end
		end
	endgenerate

	// Foreground and background accumulators; parts loadable from a register or the bus
	assign wval = (w_data_q & bmask);
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			fg_q <= '0;
			bg_q <= '0;
		end else if (bus_wr && aw_addr_q >= `OFS_ACC_BASE && aw_addr_q <= `OFS_ACC_LAST) begin
			case (aw_addr_q)
				`OFS_ACC_BASE: fg_q[79:64] <= wval[15:0];
				`OFS_ACC_BASE + 8'h04: fg_q[63:32] <= wval;
				`OFS_ACC_BASE + 8'h08: fg_q[31:0] <= wval;
				`OFS_ACC_BASE + 8'h0C: bg_q[79:64] <= wval[15:0];
				`OFS_ACC_BASE + 8'h10: bg_q[63:32] <= wval;
				default: bg_q[31:0] <= wval;
			endcase
		end else if (go_q && op == OP_REGTOACC) begin
			case (fmt[1:0])
				2'h2: if (use_bg) bg_q[79:64] <= x[15:0]; else fg_q[79:64] <= x[15:0];
				2'h1: if (use_bg) bg_q[63:32] <= x; else fg_q[63:32] <= x;
				default: if (use_bg) bg_q[31:0] <= x; else fg_q[31:0] <= x;
			endcase
		end else if (go_q && acc_wr) begin
			if (use_bg) bg_q <= acc_new;
			else fg_q <= acc_new;
		end
	end

	// Flag pins cross from outside: a bit changes once the second and third stages agree
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			flag_s1_q <= 4'h0;
			flag_s2_q <= 4'h0;
			flag_s3_q <= 4'h0;
			flag_q <= 4'h0;
		end else begin
			flag_s1_q <= FLAG_IN;
			flag_s2_q <= flag_s1_q;
			flag_s3_q <= flag_s2_q;
			flag_q <= (flag_s2_q & ~(flag_s2_q ^ flag_s3_q)) | (flag_q & (flag_s2_q ^ flag_s3_q));
		end
	end

	// Arithmetic status: unit flags follow each op, compare accumulator shifts on compare
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			arith_status_word_q <= 32'h0;
		end else begin
			arith_status_word_q[`AST_FLAG_LSB +: 4] <= flag_q;
			if (go_q) begin
				arith_status_word_q[`AST_TF] <= x[y[4:0]];
				if (fix_op) begin
					arith_status_word_q[`AST_AZ] <= (fr[31:0] == 32'h0);
					arith_status_word_q[`AST_AN] <= fr[31];
					arith_status_word_q[`AST_AV] <= fr[32];
					arith_status_word_q[`AST_AC] <= fr[33];
				end
				if (flt_op) begin
					arith_status_word_q[`AST_AZ] <= (res_a[30:0] == 31'h0);
					arith_status_word_q[`AST_AN] <= res_a[31];
					arith_status_word_q[`AST_AV] <= fov;
					arith_status_word_q[`AST_AI] <= ai;
				end
				if (mul_op) begin
					arith_status_word_q[`AST_MN] <= acc_new[79];
					arith_status_word_q[`AST_MV] <= mv;
				end
				// Sign corrected by overflow, so a wrapped difference still compares right
				if (op == OP_COMP) arith_status_word_q[`AST_CACC_LSB +: 8] <= {!(fr[31] ^ fr[32]) && fr[31:0] != 32'h0,
					arith_status_word_q[`AST_CACC_LSB + 1 +: 7]};
			end
		end
	end

	// Sticky exceptions: a new event wins over a clear in the same cycle
	logic [31:0] sticky_set, sticky_clr;
	// Float flags only count at the launch cycle, else a held command would block the clear
	assign sticky_set = {25'h0, CBUF_OVF, go_q && ai, go_q && fun, go_q && fov, go_q && mul_op && mv,
		go_q && fix_op && fr[32]};
	assign sticky_clr = (bus_wr && aw_addr_q == `OFS_STICKY_STATUS_WORD_CLR) ? (w_data_q & bmask) : 32'h0;
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			sticky_q <= 32'h0;
			IRQ <= 1'b0;
		end else begin
			sticky_q <= (((sticky_q & ~sticky_clr) | sticky_set) & `STK_STICKY_MASK) | {21'h0, STACK_STAT, 8'h0};
			IRQ <= |(sticky_q & sticky_status_word_en_q & `STK_STICKY_MASK);
		end
	end

	// AXI4-Lite read side: one read at a time, data registered with the answer
	logic [31:0] rd_val;
	logic rd_ok;
	always_comb begin
		rd_ok = ARADDR[1:0] == 2'h0;
		rd_val = 32'h0;
		if (ARADDR >= `OFS_RF_BASE) rd_val = rf_q[ARADDR[5:2]];
		else if (ARADDR == `OFS_CMD) rd_val = cmd_q;
		else if (ARADDR == `OFS_MODE) rd_val = mode_q;
		else if (ARADDR == `OFS_ARITH_STATUS_WORD) rd_val = arith_status_word_q;
		else if (ARADDR == `OFS_STICKY_STATUS_WORD) rd_val = sticky_q;
		else if (ARADDR == `OFS_STICKY_STATUS_WORD_EN) rd_val = sticky_status_word_en_q;
		else if (ARADDR == `OFS_ACC_BASE) rd_val = {16'h0, fg_q[79:64]};
		else if (ARADDR == `OFS_ACC_BASE + 8'h04) rd_val = fg_q[63:32];
		else if (ARADDR == `OFS_ACC_BASE + 8'h08) rd_val = fg_q[31:0];
		else if (ARADDR == `OFS_ACC_BASE + 8'h0C) rd_val = {16'h0, bg_q[79:64]};
		else if (ARADDR == `OFS_ACC_BASE + 8'h10) rd_val = bg_q[63:32];
		else if (ARADDR == `OFS_ACC_LAST) rd_val = bg_q[31:0];
		else rd_ok = ARADDR == `OFS_STICKY_STATUS_WORD_CLR;
	end
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			ARREADY <= 1'b1;
			RVALID <= 1'b0;
			RDATA <= 32'h0;
			RRESP <= `RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b1;
			RDATA <= rd_ok ? rd_val : 32'h0;
			RRESP <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
			ARREADY <= 1'b1;
		end
	end

	// Checks on the datapath
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	addsub_pair_a: assert property (go_q && op == OP_ADDSUB && rn != rm && !mode_q[`MODE_SAT] |=>
		rf_q[$past(rn)] == $past(x + y) && rf_q[$past(rm)] == $past(x - y)) else $error("dual add/sub wrong");
	fl_pair_a: assert property (go_q && op == OP_FADDSUB && rn != rm |=>
		rf_q[$past(rn)] == $past(fa[31:0]) && rf_q[$past(rm)] == $past(fb[31:0])) else $error("dual float wrong");
	sat_limit_a: assert property (go_q && op == OP_ADD && mode_q[`MODE_SAT] && fr[32] && !x[31] |=>
		rf_q[$past(rn)] == 32'h7FFFFFFF) else $error("no saturation");
	zero_flag_a: assert property (go_q && fix_op |=> arith_status_word_q[`AST_AZ] == ($past(fr[31:0]) == 32'h0))
		else $error("zero flag wrong");
	sticky_hold_a: assert property (sticky_q[`STK_AOS] && !sticky_clr[`STK_AOS] |=> sticky_q[`STK_AOS])
		else $error("sticky bit lost");
	part_load_a: assert property (go_q && op == OP_REGTOACC && !use_bg && fmt[1:0] == 2'h2 |=>
		fg_q[79:64] == $past(x[15:0]) && bg_q == $past(bg_q)) else $error("upper part load wrong");
	bg_clear_a: assert property (go_q && op == OP_ACLR && use_bg && !to_reg |=>
		bg_q == '0 && fg_q == $past(fg_q)) else $error("background clear wrong");
	uint_mul_a: assert property (go_q && op == OP_MUL && fmt == 4'h0 && !use_bg && !to_reg |=>
		fg_q[63:0] == $past(x) * $past(y)) else $error("unsigned product wrong");
	default_fmt_a: assert property (go_q && op == OP_ATOREG && !cmd_q[`CMD_FMTGIVEN_BIT] |=>
		rf_q[$past(rn)] == {{16{$past(acc_src[79])}}, $past(acc_src[79:64])})
		else $error("one-input default not signed fractional");
	irq_level_a: assert property (##1 IRQ == |$past(sticky_q & sticky_status_word_en_q & `STK_STICKY_MASK))
		else $error("interrupt level wrong");

	cv_mac: cover property ((go_q && op == OP_MACP) ##[1:40] (go_q && op == OP_ATOREG));
	cv_fl: cover property (go_q && op == OP_FADDSUB);
	cv_irq: cover property (IRQ ##[1:20] !IRQ);

endmodule : dsp_alu_multiplier_core
`default_nettype wire

// ---- flag_source.sv ----
// Partner model driving flag pins and address-logic status into the datapath
`timescale 1ns/1ps
`default_nettype none
module flag_source (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [3:0] flags_req,
	input wire logic cbuf_hit,
	input wire logic [2:0] stack_req,
	output logic [3:0] FLAG_IN,
	output logic [1:0] CBUF_OVF,
	output logic [2:0] STACK_STAT
);
	// Overflow is a one-cycle pulse, so only a true sticky capture keeps it
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			FLAG_IN <= 4'h0;
			CBUF_OVF <= 2'h0;
			STACK_STAT <= 3'h0;
		end else begin
			FLAG_IN <= flags_req;
			CBUF_OVF <= {1'b0, cbuf_hit};
			STACK_STAT <= stack_req;
		end
	end
endmodule : flag_source
`default_nettype wire

// ---- tb_dsp_alu_multiplier_core.sv ----
// Self-checking bench for the compute datapath behind its register bus
`timescale 1ns/1ps
`default_nettype none
`include "dsp_alu_map.svh"
module tb_dsp_alu_multiplier_core
	import dsp_alu_pkg::*;
;
	logic CLOCK = 1'b0;
	logic RST = 1'b1;
	logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic [31:0] WDATA = 32'h0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
	logic [1:0] BRESP, RRESP, rr, CBUF_OVF;
	logic [31:0] RDATA, rd;
	logic [3:0] FLAG_IN, flags_req = 4'h0;
	logic [2:0] STACK_STAT, stack_req = 3'h0;
	logic cbuf_hit = 1'b0;
	int failures = 0;
	int n_tests = 0;
	// Carry forms follow DEC, whose carry out is one, and each leaves a known carry for the next
	alu_op_t ops [18] = '{OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MAX, OP_MIN, OP_INC, OP_DEC, OP_ADDCI, OP_SUBCI,
		OP_INCCI, OP_DECCI, OP_NEG, OP_AVG, OP_NOT, OP_CLIP, OP_ABS, OP_PASS};
	logic [31:0] res [18] = '{32'h2, 32'h1, 32'h7, 32'h6, 32'h5, 32'h3, 32'h6, 32'h4, 32'h9, 32'h1, 32'h6, 32'h4,
		32'hFFFFFFFB, 32'h4, 32'hFFFFFFFA, 32'h3, 32'h5, 32'h5};

	always #5 CLOCK = ~CLOCK;

	dsp_alu_multiplier_core i_dsp_alu_multiplier_core (.CLOCK(CLOCK), .RST(RST), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.FLAG_IN(FLAG_IN), .CBUF_OVF(CBUF_OVF), .STACK_STAT(STACK_STAT), .IRQ(IRQ));
	flag_source i_flag_source (.CLOCK(CLOCK), .RST(RST), .flags_req(flags_req), .cbuf_hit(cbuf_hit),
		.stack_req(stack_req), .FLAG_IN(FLAG_IN), .CBUF_OVF(CBUF_OVF), .STACK_STAT(STACK_STAT));

	task automatic complete_run;
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Every handshake wait goes through here, so a stuck handshake ends the run
	task automatic tick(inout int n);
		@(posedge CLOCK);
		n++;
		if (n > 60) begin
			failures++;
			complete_run();
		end
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n = 0;
		logic aw = 1'b0;
		logic w = 1'b0;
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		// Address and data may be taken at different edges
		while (!(aw && w)) begin
			tick(n);
			aw = aw | AWREADY;
			w = w | WREADY;
			AWVALID <= !aw;
			WVALID <= !w;
		end
		BREADY <= 1'b1;
		do tick(n); while (!BVALID);
		BREADY <= 1'b0;
		chk({30'h0, BRESP}, {30'h0, er});
	endtask : wr

	task automatic rdw(input logic [7:0] a);
		int n = 0;
		ARADDR <= a;
		ARVALID <= 1'b1;
		do tick(n); while (!ARREADY);
		ARVALID <= 1'b0;
		RREADY <= 1'b1;
		do tick(n); while (!RVALID);
		RREADY <= 1'b0;
		rd = RDATA;
		rr = RRESP;
	endtask : rdw

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rdw(a);
		chk(rd, e);
	endtask : rc

	// Command effect lands one edge after the write response
	task automatic cmd(input logic [31:0] c);
		wr(`OFS_CMD, c, 2'h0);
		@(posedge CLOCK);
	endtask : cmd

	function automatic logic [7:0] ra(input logic [3:0] i);
		return {2'b01, i, 2'b00};
	endfunction : ra

	function automatic logic [31:0] opw(input alu_op_t op, input logic [3:0] rn, input logic [3:0] rm,
		input logic [3:0] rx, input logic [3:0] ry);
		return {8'h00, ry, rx, rm, rn, 2'b00, op};
	endfunction : opw

	task automatic t_regs;
		rc(`OFS_MODE, 32'h0);
		wr(ra(4'hF), 32'hA5A5A5A5, 2'h0);
		rc(ra(4'hF), 32'hA5A5A5A5);
		wr(8'h18, 32'h1, 2'h2);
		rdw(8'h1A);
		chk({30'h0, rr}, 32'h2);
	endtask : t_regs

	task automatic t_dual;
		wr(ra(4'h1), 32'h5, 2'h0);
		wr(ra(4'h2), 32'h3, 2'h0);
		cmd(opw(OP_ADDSUB, 4'h4, 4'h5, 4'h1, 4'h2));
		rc(ra(4'h4), 32'h8);
		rc(ra(4'h5), 32'h2);
		wr(ra(4'hA), 32'h3FC00000, 2'h0);
		wr(ra(4'hB), 32'h3F800000, 2'h0);
		cmd(opw(OP_FADDSUB, 4'h6, 4'h7, 4'hA, 4'hB));
		rc(ra(4'h6), 32'h40200000);
		rc(ra(4'h7), 32'h3F000000);
	endtask : t_dual

	task automatic t_ops;
		foreach (ops[k]) begin
			cmd(opw(ops[k], 4'h6, 4'h0, 4'h1, 4'h2));
			rc(ra(4'h6), res[k]);
		end
	endtask : t_ops

	task automatic t_sat;
		wr(ra(4'h7), 32'h7FFFFFFF, 2'h0);
		wr(ra(4'h8), 32'h1, 2'h0);
		cmd(opw(OP_ADD, 4'h9, 4'h0, 4'h7, 4'h8));
		rc(ra(4'h9), 32'h80000000);
		wr(`OFS_MODE, 32'h1, 2'h0);
		cmd(opw(OP_ADD, 4'h9, 4'h0, 4'h7, 4'h8));
		rc(ra(4'h9), 32'h7FFFFFFF);
		rdw(`OFS_ARITH_STATUS_WORD);
		chk(rd & 32'h2, 32'h2);
		cmd(opw(OP_ADD, 4'h9, 4'h0, 4'h1, 4'h2));
		rc(`OFS_STICKY_STATUS_WORD, 32'h1);
		chk({31'h0, IRQ}, 32'h0);
		wr(`OFS_STICKY_STATUS_WORD_EN, 32'h21, 2'h0);
		repeat (2) @(posedge CLOCK);
		chk({31'h0, IRQ}, 32'h1);
		wr(`OFS_STICKY_STATUS_WORD_CLR, 32'h1, 2'h0);
		repeat (2) @(posedge CLOCK);
		chk({31'h0, IRQ}, 32'h0);
		cbuf_hit <= 1'b1;
		flags_req <= 4'hA;
		stack_req <= 3'h5;
		@(posedge CLOCK);
		cbuf_hit <= 1'b0;
		repeat (8) @(posedge CLOCK);
		chk({31'h0, IRQ}, 32'h1);
		rdw(`OFS_ARITH_STATUS_WORD);
		chk(rd & 32'h000F0000, 32'h000A0000);
		rc(`OFS_STICKY_STATUS_WORD, 32'h520);
		stack_req <= 3'h0;
		repeat (3) @(posedge CLOCK);
		rc(`OFS_STICKY_STATUS_WORD, 32'h20);
	endtask : t_sat

	task automatic t_acc;
		// Unsigned integer product of an all-ones word differs from the signed one
		wr(ra(4'hC), 32'hFFFFFFFF, 2'h0);
		cmd(opw(OP_MUL, 4'h0, 4'h0, 4'hC, 4'h1) | 32'h20000000);
		rc(8'h24, 32'h4);
		rc(8'h28, 32'hFFFFFFFB);
		cmd(opw(OP_MUL, 4'h0, 4'h0, 4'h1, 4'h2));
		rc(8'h28, 32'hF);
		rc(8'h34, 32'h0);
		cmd(opw(OP_MUL, 4'h0, 4'h0, 4'h1, 4'h2) | 32'h3E000000);
		rc(8'h34, 32'h1E);
		rc(8'h28, 32'hF);
		wr(8'h24, 32'hA5A5A5A5, 2'h0);
		rc(8'h24, 32'hA5A5A5A5);
		cmd(opw(OP_ACLR, 4'h0, 4'h0, 4'h0, 4'h0) | 32'h10000000);
		rc(8'h34, 32'h0);
		rc(8'h28, 32'hF);
		wr(8'h20, 32'h00008001, 2'h0);
		cmd(opw(OP_ATOREG, 4'h3, 4'h0, 4'h0, 4'h0));
		rc(ra(4'h3), 32'hFFFF8001);
		cmd(opw(OP_REGTOACC, 4'h0, 4'h0, 4'h1, 4'h0) | 32'h21000000);
		rc(8'h24, 32'h5);
	endtask : t_acc

	initial begin
		repeat (16) @(posedge CLOCK);
		RST <= 1'b0;
		@(posedge CLOCK);
		t_regs();
		t_dual();
		t_ops();
		t_sat();
		t_acc();
		complete_run();
	end
endmodule : tb_dsp_alu_multiplier_core
`default_nettype wire
